// ### rtl/eiwp_consts.vh
// Constants for the extended code write protection block
// Assumes inclusion by bare name from the storage model, the top and the assertions
`ifndef EIWP_CONSTS_VH
`define EIWP_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// Widths
`define EIWP_CODE_W        4
`define EIWP_ADDR_W        2

////////////////////////////////////////////////////////////////////////
// Register indices, also the nonvolatile user area word addresses
`define EIWP_ADDR_STATUS   2'h0
`define EIWP_ADDR_USER     2'h1
`define EIWP_ADDR_PROT     2'h2
`define EIWP_ADDR_FLAGS    2'h3
`define EIWP_NUM_WORDS     4

////////////////////////////////////////////////////////////////////////
// Field positions of the flags word
`define EIWP_FLAG_LOCK     0
`define EIWP_FLAG_INHIBIT  1

////////////////////////////////////////////////////////////////////////
// Field positions of the status word
`define EIWP_ST_BUSY       0
`define EIWP_ST_REFUSED    1
`define EIWP_ST_DUAL       2
`define EIWP_ST_DROPPED    3

////////////////////////////////////////////////////////////////////////
// Code fields: selector bit and top of the compared low bits
`define EIWP_SEL_BIT       3
`define EIWP_LOW_MSB       2

////////////////////////////////////////////////////////////////////////
// Codes and reset values
`define EIWP_PROFILE_EXT   4'ha
`define EIWP_WRITE_REPLY   4'h0
`define EIWP_NV_INIT       4'h0
`define EIWP_ZERO_CODE     4'h0

`endif

// ### rtl/eiwp_rst_sync.v
// Reset release synchroniser: two flip-flops on the core clock
// Assumes an asynchronous active-low reset from outside the clock domain
`timescale 1ns/100ps
`default_nettype none

module eiwp_rst_sync
(
    // Clock and raw reset
    input  wire i_core_clk,
    input  wire i_rst_n,
    // Synchronised reset
    output wire o_rst_n
);

////////////////////////////////////////////////////////////////////////
reg stage_one;
reg stage_two;

// Assertion is immediate, release waits two edges
always @(posedge i_core_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        stage_one <= 1'b0;
        stage_two <= 1'b0;
    end
    else
    begin
        stage_one <= 1'b1;
        stage_two <= stage_one;
    end
end

assign o_rst_n = stage_two;

endmodule // eiwp_rst_sync

`default_nettype wire

// ### rtl/eiwp_nvmem.v
// Small model of the nonvolatile user area: four 4-bit words
// Assumes one writer at a time; both read ports answer one cycle later
`timescale 1ns/100ps
`default_nettype none
`include "eiwp_consts.vh"

module eiwp_nvmem
(
    // Clock and reset
    input  wire                       i_core_clk,
    input  wire                       i_rst_n,
    // Write port
    input  wire                       i_we,
    input  wire [`EIWP_ADDR_W-1:0]    i_waddr,
    input  wire [`EIWP_CODE_W-1:0]    i_wdata,
    // Read port A, used by the request sequencer
    input  wire [`EIWP_ADDR_W-1:0]    i_a_addr,
    output reg  [`EIWP_CODE_W-1:0]    o_a_data,
    // Read port B, used by software; word 0 returns the aux value
    input  wire [`EIWP_ADDR_W-1:0]    i_b_addr,
    input  wire [`EIWP_CODE_W-1:0]    i_b_aux,
    output reg  [`EIWP_CODE_W-1:0]    o_b_data
);

////////////////////////////////////////////////////////////////////////
wire [`EIWP_NUM_WORDS*`EIWP_CODE_W-1:0] flat;
// One-hot word select keeps the compare free of genvar slicing
wire [`EIWP_NUM_WORDS-1:0]              word_sel;

assign word_sel = {{(`EIWP_NUM_WORDS-1){1'b0}}, i_we} << i_waddr;

genvar g;
generate
    for (g = 0; g < `EIWP_NUM_WORDS; g = g + 1)
    begin : gen_word
        reg [`EIWP_CODE_W-1:0] word;
        always @(posedge i_core_clk or negedge i_rst_n)
        begin
            if (!i_rst_n)
                word <= `EIWP_NV_INIT;
            else if (word_sel[g])
                word <= i_wdata;
        end
        assign flat[g*`EIWP_CODE_W +: `EIWP_CODE_W] = word;
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// Registered reads
always @(posedge i_core_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        o_a_data <= `EIWP_ZERO_CODE;
        o_b_data <= `EIWP_ZERO_CODE;
    end
    else
    begin
        o_a_data <= flat[{i_a_addr, 2'h0} +: `EIWP_CODE_W];
        if (i_b_addr == `EIWP_ADDR_STATUS)
            o_b_data <= i_b_aux;
        else
            o_b_data <= flat[{i_b_addr, 2'h0} +: `EIWP_CODE_W];
    end
end

endmodule // eiwp_nvmem

`default_nettype wire

// ### rtl/eiwp_top.v
// Write protection and read-out of the first extended code
// Assumes request pulses come from protocol logic on the same core clock
`timescale 1ns/100ps
`default_nettype none
`include "eiwp_consts.vh"

// Summary of operation
// R1 - Inhibit set: read reply from protected copy
// R2 - Extended mode: reply bit 3 from user copy
// R3 - Inhibit set, mismatch: no write, no reply
// R4 - Master changes only bit 3, keeps rest
// R5 - Inhibit clear: read reply from user copy
// R6 - Inhibit clear: always reply and write
// R7 - Lock clear: write both user and protected copies
// R8 - Profile hex A: compare only bits 2..0
// R9 - Lock set: write user copy only
// R10 - Write reply data is always zero
// R11 - Flags sampled from storage before deciding
module eiwp_top
(
    // Clock and reset
    input  wire                       i_core_clk,
    input  wire                       i_rst_n,
    // Requests from the protocol engine
    input  wire                       i_read_code_one_request,
    input  wire                       i_write_code_one_request,
    input  wire [`EIWP_CODE_W-1:0]    i_write_data,
    input  wire [`EIWP_CODE_W-1:0]    i_slave_profile_code,
    // Replies to the protocol engine
    output reg                        o_reply_valid,
    output reg  [`EIWP_CODE_W-1:0]    o_reply_data,
    output reg                        o_write_refused,
    output reg                        o_busy,
    // Register port
    input  wire [`EIWP_ADDR_W-1:0]    i_reg_addr,
    input  wire [`EIWP_CODE_W-1:0]    i_reg_wdata,
    input  wire                       i_reg_wr,
    input  wire                       i_reg_rd,
    output wire [`EIWP_CODE_W-1:0]    o_reg_rdata
);

////////////////////////////////////////////////////////////////////////
// States
localparam [6:0] S_IDLE    = 7'h01;
localparam [6:0] S_FLAGS   = 7'h02;
localparam [6:0] S_USER    = 7'h04;
localparam [6:0] S_PROT    = 7'h08;
localparam [6:0] S_DECIDE  = 7'h10;
localparam [6:0] S_WR_USER = 7'h20;
localparam [6:0] S_WR_PROT = 7'h40;

////////////////////////////////////////////////////////////////////////
// Declarations
wire                     rst_n;
reg  [6:0]               state;
reg  [6:0]               next_state;
reg                      req_is_write;
reg  [`EIWP_CODE_W-1:0]  req_data;
reg                      req_ext;
reg                      flag_lock;
reg                      flag_inhibit;
reg  [`EIWP_CODE_W-1:0]  user_val;
reg  [`EIWP_CODE_W-1:0]  prot_val;
reg                      st_refused;
reg                      st_dual;
reg                      st_dropped;
reg  [`EIWP_ADDR_W-1:0]  a_addr;
reg                      fsm_we;
reg  [`EIWP_ADDR_W-1:0]  fsm_waddr;
wire [`EIWP_CODE_W-1:0]  a_data;
wire                     any_req;
wire                     both_req;
wire                     take_req;
wire                     sw_wr_mem;
wire                     sw_lost;
wire                     mem_we;
wire [`EIWP_ADDR_W-1:0]  mem_waddr;
wire [`EIWP_CODE_W-1:0]  mem_wdata;
wire [`EIWP_CODE_W-1:0]  status_word;
wire                     code_match;
wire [`EIWP_CODE_W-1:0]  read_reply;
wire                     st_clear_wr;

////////////////////////////////////////////////////////////////////////
// Reset release
eiwp_rst_sync u_rst_sync
(
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .o_rst_n    (rst_n)
);

////////////////////////////////////////////////////////////////////////
// Request intake; one request in flight, others are dropped
assign any_req  = i_read_code_one_request | i_write_code_one_request;
assign both_req = i_read_code_one_request & i_write_code_one_request;
assign take_req = any_req & (state == S_IDLE);

////////////////////////////////////////////////////////////////////////
// Decision terms
// Profile A keeps bit 3 as the A/B selector, so it is never compared
assign code_match = req_ext ?
    (req_data[`EIWP_LOW_MSB:0] ==
     prot_val[`EIWP_LOW_MSB:0]) :                           // see R8
    (req_data == prot_val);                                 // see R3

// Protected value answers while inhibited, bit 3 stays user's in
// extended mode so a selector change written by the master reads back
assign read_reply = !flag_inhibit ? user_val :              // see R5
    (req_ext ? {user_val[`EIWP_SEL_BIT],
                prot_val[`EIWP_LOW_MSB:0]} :                // see R2
     prot_val);                                             // see R1

////////////////////////////////////////////////////////////////////////
// Sequencer: flags, user copy and protected copy are read for every
// request, so a flag changed just before a request is honoured
always @*
begin
    next_state = state;
    a_addr     = `EIWP_ADDR_FLAGS;
    fsm_we     = 1'b0;
    fsm_waddr  = `EIWP_ADDR_USER;
    case (state)
        S_IDLE:
        begin
            a_addr = `EIWP_ADDR_FLAGS;                      // see R11
            if (take_req)
                next_state = S_FLAGS;
        end
        S_FLAGS:
        begin
            a_addr     = `EIWP_ADDR_USER;
            next_state = S_USER;
        end
        S_USER:
        begin
            a_addr     = `EIWP_ADDR_PROT;
            next_state = S_PROT;
        end
        S_PROT:
            next_state = S_DECIDE;
        S_DECIDE:
        begin
            if (!req_is_write)
                next_state = S_IDLE;
            else if (flag_inhibit && !code_match)
                next_state = S_IDLE;                        // see R3
            else
                next_state = S_WR_USER;                     // see R6
        end
        S_WR_USER:
        begin
            fsm_we    = 1'b1;
            fsm_waddr = `EIWP_ADDR_USER;
            if (flag_lock)
                next_state = S_IDLE;                        // see R9
            else
                next_state = S_WR_PROT;                     // see R7
        end
        S_WR_PROT:
        begin
            fsm_we     = 1'b1;
            fsm_waddr  = `EIWP_ADDR_PROT;                   // see R7
            next_state = S_IDLE;
        end
        default:
            next_state = S_IDLE;
    endcase
end

always @(posedge i_core_clk or negedge rst_n)
begin
    if (!rst_n)
        state <= S_IDLE;
    else
        state <= next_state;
end

////////////////////////////////////////////////////////////////////////
// Captured request and sampled storage
always @(posedge i_core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        req_is_write <= 1'b0;
        req_data     <= `EIWP_ZERO_CODE;
        req_ext      <= 1'b0;
        flag_lock    <= 1'b0;
        flag_inhibit <= 1'b0;
        user_val     <= `EIWP_ZERO_CODE;
        prot_val     <= `EIWP_ZERO_CODE;
    end
    else
    begin
        if (take_req)
        begin
            // Write wins when both strobes coincide
            req_is_write <= i_write_code_one_request;
            req_data     <= i_write_data;
            req_ext      <= (i_slave_profile_code == `EIWP_PROFILE_EXT);
        end
        if (state == S_FLAGS)
        begin
            flag_lock    <= a_data[`EIWP_FLAG_LOCK];        // see R11
            flag_inhibit <= a_data[`EIWP_FLAG_INHIBIT];     // see R11
        end
        if (state == S_USER)
            user_val <= a_data;
        if (state == S_PROT)
            prot_val <= a_data;
    end
end

////////////////////////////////////////////////////////////////////////
// Replies
always @(posedge i_core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        o_reply_valid   <= 1'b0;
        o_reply_data    <= `EIWP_ZERO_CODE;
        o_write_refused <= 1'b0;
        o_busy          <= 1'b0;
    end
    else
    begin
        o_reply_valid   <= 1'b0;
        o_write_refused <= 1'b0;
        o_busy          <= (next_state != S_IDLE);
        if (state == S_DECIDE && !req_is_write)
        begin
            o_reply_valid <= 1'b1;
            o_reply_data  <= read_reply;                    // see R1
        end
        else if (state == S_DECIDE && flag_inhibit && !code_match)
            o_write_refused <= 1'b1;                        // see R3
        else if ((state == S_WR_USER && flag_lock) ||
                 state == S_WR_PROT)
        begin
            o_reply_valid <= 1'b1;                          // see R6
            o_reply_data  <= `EIWP_WRITE_REPLY;             // see R10
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Status flags; a new event beats a software clear in the same cycle
assign st_clear_wr = i_reg_wr && (i_reg_addr == `EIWP_ADDR_STATUS);

always @(posedge i_core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        st_refused <= 1'b0;
        st_dual    <= 1'b0;
        st_dropped <= 1'b0;
    end
    else
    begin
        if (state == S_DECIDE && req_is_write && flag_inhibit &&
            !code_match)
            st_refused <= 1'b1;
        else if (st_clear_wr && i_reg_wdata[`EIWP_ST_REFUSED])
            st_refused <= 1'b0;

        if (state == S_WR_PROT)
            st_dual <= 1'b1;
        else if (st_clear_wr && i_reg_wdata[`EIWP_ST_DUAL])
            st_dual <= 1'b0;

        if ((any_req && state != S_IDLE) || both_req || sw_lost)
            st_dropped <= 1'b1;
        else if (st_clear_wr && i_reg_wdata[`EIWP_ST_DROPPED])
            st_dropped <= 1'b0;
    end
end

assign status_word = {st_dropped, st_dual, st_refused, o_busy};

////////////////////////////////////////////////////////////////////////
// Storage write arbitration
// The sequencer owns the write port during its write states; a software
// write there is lost and flagged rather than stalling the register port
assign sw_wr_mem = i_reg_wr && (i_reg_addr != `EIWP_ADDR_STATUS);
assign sw_lost   = sw_wr_mem & fsm_we;
assign mem_we    = fsm_we | sw_wr_mem;
assign mem_waddr = fsm_we ? fsm_waddr : i_reg_addr;
assign mem_wdata = fsm_we ? req_data : i_reg_wdata;         // see R7

eiwp_nvmem u_nvmem
(
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n),
    .i_we       (mem_we),
    .i_waddr    (mem_waddr),
    .i_wdata    (mem_wdata),
    .i_a_addr   (a_addr),
    .o_a_data   (a_data),
    .i_b_addr   (i_reg_addr),
    .i_b_aux    (status_word),
    .o_b_data   (o_reg_rdata)
);

// The read strobe only qualifies the cycle; the port answers every cycle
wire unused_rd;
assign unused_rd = i_reg_rd;

endmodule // eiwp_top

`default_nettype wire

// ### dv/eiwp_top_assertions.sv
// Port assertions for the extended code protection block
// Assumes a bind onto eiwp_top placed in the bench top file
`timescale 1ns/100ps
`default_nettype none
`include "eiwp_consts.vh"

module eiwp_top_assertions
(
    // Clock and reset
    input wire logic                    i_core_clk,
    input wire logic                    i_rst_n,
    // Requests and replies
    input wire logic                    i_read_code_one_request,
    input wire logic                    i_write_code_one_request,
    input wire logic                    o_reply_valid,
    input wire logic [`EIWP_CODE_W-1:0] o_reply_data,
    input wire logic                    o_write_refused,
    input wire logic                    o_busy
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    // A write beats a read in the same cycle
    wire rd_go = i_read_code_one_request && !i_write_code_one_request
                 && !o_busy;
    wire wr_go = i_write_code_one_request && !o_busy;

    // Outputs rise after the fourth, fifth or sixth edge past the
    // request edge, so they are sampled one edge later
    sequence s_refuse;
        ##5 o_write_refused;
    endsequence
    sequence s_single;
        ##6 (o_reply_valid && o_reply_data == `EIWP_WRITE_REPLY);
    endsequence
    sequence s_dual;
        ##7 (o_reply_valid && o_reply_data == `EIWP_WRITE_REPLY);
    endsequence

    ////////////////////////////////////////////////////////////////////
    chk_read_latency: assert property (
        rd_go |=> o_busy [*4] ##1 (o_reply_valid && !o_busy))
        else $error("read reply not four cycles after request");
    chk_write_answer: assert property (
        wr_go |-> s_refuse or s_single or s_dual)
        else $error("write answer missing or not zero");
    chk_refused_quiet: assert property (
        o_write_refused |-> !o_reply_valid ##1 !o_reply_valid [*2])
        else $error("reply sent for refused write");
    chk_write_busy: assert property (
        wr_go |=> o_busy)
        else $error("write request not taken");
    chk_reply_pulse: assert property (
        o_reply_valid |=> !o_reply_valid)
        else $error("reply pulse longer than one cycle");
    chk_refused_pulse: assert property (
        o_write_refused |=> !o_write_refused)
        else $error("refused pulse longer than one cycle");
    chk_data_hold: assert property (
        !o_reply_valid |-> $stable(o_reply_data))
        else $error("reply data moved without a reply");
    chk_reply_cause: assert property (
        o_reply_valid |-> $past(o_busy))
        else $error("reply without a request in flight");
endmodule // eiwp_top_assertions
`default_nettype wire

// ### dv/eiwp_master_model.sv
// Network master model issuing code read and write requests
// Assumes the bench calls its tasks; replies are sampled after edges
`timescale 1ns/100ps
`default_nettype none

module eiwp_master_model
(
    // Clock and replies
    input  wire logic       i_core_clk,
    input  wire logic       i_reply_valid,
    input  wire logic [3:0] i_reply_data,
    input  wire logic       i_write_refused,
    // Requests
    output var  logic       o_read_req,
    output var  logic       o_write_req,
    output var  logic [3:0] o_write_data,
    output var  logic [3:0] o_profile
);
    initial
    begin
        o_read_req = 1'b0;
        o_write_req = 1'b0;
        o_write_data = 4'h0;
        o_profile = 4'h0;
    end

    // Fixed eight-cycle watch also catches late replies after a refusal
    task automatic request(input logic wr, input logic [3:0] d,
        input logic [3:0] p, output logic got, output logic refd,
        output logic [3:0] q, output logic hung);
        int n;
        @(posedge i_core_clk);
        o_read_req <= !wr;
        o_write_req <= wr;
        o_write_data <= d;
        o_profile <= p;
        @(posedge i_core_clk);
        o_read_req <= 1'b0;
        o_write_req <= 1'b0;
        // Released data line must not keep the last value
        o_write_data <= ~d;
        got = 1'b0;
        refd = 1'b0;
        q = 4'h0;
        for (n = 0; n < 8; n++)
        begin
            @(posedge i_core_clk);
            #1;
            if (i_reply_valid === 1'b1)
            begin
                got = 1'b1;
                q = i_reply_data;
            end
            if (i_write_refused === 1'b1)
                refd = 1'b1;
        end
        hung = !(got || refd);
    endtask

    // Selector change: read first, then alter bit 3 only
    task automatic flip_selector(input logic [3:0] p, output logic hung);
        logic g, r, h;
        logic [3:0] q;
        request(1'b0, 4'h0, p, g, r, q, h);
        request(1'b1, {~q[3], q[2:0]}, p, g, r, q, hung);
        hung = hung | h;
    endtask
endmodule // eiwp_master_model
`default_nettype wire

// ### dv/eiwp_top_bench.sv
// Self-checking bench for the extended code protection block
// Assumes the master model drives requests and tasks here the registers
`timescale 1ns/100ps
`default_nettype none

module eiwp_top_bench;
    logic       i_core_clk, i_rst_n, reg_wr, reg_rd, got, refd, hung;
    logic [1:0] reg_addr;
    logic [3:0] reg_wdata, q;
    wire        rd_req, wr_req, reply_valid, write_refused, busy;
    wire  [3:0] wr_data, profile, reply_data, reg_rdata;
    int         err_count, total_checks;

    eiwp_top eiwp_top_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_read_code_one_request(rd_req), .i_write_code_one_request(wr_req),
        .i_write_data(wr_data), .i_slave_profile_code(profile),
        .o_reply_valid(reply_valid), .o_reply_data(reply_data),
        .o_write_refused(write_refused), .o_busy(busy),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));
    eiwp_master_model eiwp_master_model_i (.i_core_clk(i_core_clk),
        .i_reply_valid(reply_valid), .i_reply_data(reply_data),
        .i_write_refused(write_refused), .o_read_req(rd_req),
        .o_write_req(wr_req), .o_write_data(wr_data), .o_profile(profile));

    initial
    begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [3:0] e,
        input logic [3:0] s);
        total_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, s);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [3:0] d);
        @(posedge i_core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge i_core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [3:0] e);
        @(posedge i_core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge i_core_clk);
        reg_rd <= 1'b0;
        #1;
        cmp("register", e, reg_rdata);
    endtask
    task print_verdict;
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Request, then compare reply, refusal flag and reply data
    task automatic go(input logic w, input logic [3:0] d, input logic [3:0] p,
        input logic eg, input logic er, input logic [3:0] eq);
        eiwp_master_model_i.request(w, d, p, got, refd, q, hung);
        if (hung && !er)
        begin
            err_count++;
            print_verdict();
        end
        cmp("reply", {3'h0, eg}, {3'h0, got});
        cmp("refused", {3'h0, er}, {3'h0, refd});
        cmp("reply data", eq, q);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        i_rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 4'h0;
        err_count = 0;
        total_checks = 0;
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (5) @(posedge i_core_clk);
        go(1'b1, 4'h5, 4'h0, 1'b1, 1'b0, 4'h0);
        rd(2'h1, 4'h5);
        rd(2'h2, 4'h5);
        rd(2'h0, 4'h4);
        wr(2'h1, 4'h9);
        go(1'b0, 4'h0, 4'h0, 1'b1, 1'b0, 4'h9);
        go(1'b0, 4'h0, 4'ha, 1'b1, 1'b0, 4'h9);
        wr(2'h3, 4'h2);
        go(1'b0, 4'h0, 4'h0, 1'b1, 1'b0, 4'h5);
        go(1'b0, 4'h0, 4'ha, 1'b1, 1'b0, 4'hd);
        go(1'b1, 4'h6, 4'h0, 1'b0, 1'b1, 4'h0);
        go(1'b1, 4'hd, 4'h0, 1'b0, 1'b1, 4'h0);
        rd(2'h1, 4'h9);
        rd(2'h0, 4'h6);
        wr(2'h0, 4'he);
        rd(2'h0, 4'h0);
        go(1'b1, 4'hd, 4'ha, 1'b1, 1'b0, 4'h0);
        rd(2'h2, 4'hd);
        wr(2'h3, 4'h3);
        wr(2'h1, 4'h0);
        wr(2'h2, 4'h5);
        eiwp_master_model_i.flip_selector(4'ha, hung);
        cmp("selector", 4'h0, {3'h0, hung});
        rd(2'h1, 4'hd);
        rd(2'h2, 4'h5);
        go(1'b0, 4'h0, 4'ha, 1'b1, 1'b0, 4'hd);
        go(1'b0, 4'h0, 4'h0, 1'b1, 1'b0, 4'h5);
        wr(2'h3, 4'h1);
        go(1'b1, 4'h7, 4'h0, 1'b1, 1'b0, 4'h0);
        rd(2'h1, 4'h7);
        rd(2'h2, 4'h5);
        print_verdict();
    end
endmodule // eiwp_top_bench

bind eiwp_top eiwp_top_assertions eiwp_top_assertions_i (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_read_code_one_request(i_read_code_one_request),
    .i_write_code_one_request(i_write_code_one_request),
    .o_reply_valid(o_reply_valid), .o_reply_data(o_reply_data),
    .o_write_refused(o_write_refused), .o_busy(o_busy));
`default_nettype wire
